/* rtl/mfs_param_mem.sv */
`timescale 1ns/10ps
`default_nettype none

module mfs_param_mem
    import mfs_pkg::*;
#(
    parameter int unsigned WIDTH = DW,
    parameter int unsigned AW    = PARAM_AW
) (
    // clock
    input  wire logic             aclk,
    input  wire logic             ce,
    // write port
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // read port, one cycle latency
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [2**AW];

    ////////////////////////////////////////////////////////////////////////////
    // no reset on the array: contents survive a processor restart
    always_ff @(posedge aclk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end

endmodule // mfs_param_mem

`default_nettype wire

/* rtl/mfs_pkg.sv */
package mfs_pkg;

    // clock and restart timing
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned RESTART_MS     = 500;
    localparam int unsigned RESTART_CYCLES = RESTART_MS * (CLK_HZ / 1000);

    // parameter memory shape
    localparam int unsigned DW          = 32;
    localparam int unsigned PARAM_AW    = 4;
    localparam int unsigned PARAM_DEPTH = 16;
    localparam logic [4:0]  IDX_END     = 5'h10;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_STATUS     = 8'h04;
    localparam logic [7:0] OFS_ERRCODE    = 8'h08;
    localparam logic [7:0] OFS_PARAM_ADDR = 8'h0C;
    localparam logic [7:0] OFS_PARAM_DATA = 8'h10;
    localparam logic [7:0] OFS_PROG_STAGE = 8'h14;
    localparam logic [7:0] OFS_PROG       = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h20;

    // control bits (write-one pulses)
    localparam int unsigned CTRL_SAVE      = 0;
    localparam int unsigned CTRL_DL_START  = 1;
    localparam int unsigned CTRL_DL_COMMIT = 2;
    localparam int unsigned CTRL_DL_ABORT  = 3;

    // status bits
    localparam int unsigned STAT_READY = 0;
    localparam int unsigned STAT_BUSY  = 1;
    localparam int unsigned STAT_DL    = 2;
    localparam int unsigned STAT_UERR  = 3;
    localparam int unsigned STAT_HELD  = 4;

    // interrupt bits
    localparam int unsigned IRQ_READY    = 0;
    localparam int unsigned IRQ_UERR     = 1;
    localparam int unsigned IRQ_DL_ABORT = 2;
    localparam int unsigned IRQ_RESET    = 3;

    // reset values and bus answers
    localparam logic [7:0]  ERRCODE_RST = 8'h00;
    localparam logic [3:0]  MASK_RST    = 4'h0;
    localparam logic [31:0] PROG_RST    = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_HELD,
        ST_RELOAD,
        ST_BOOT,
        ST_READY,
        ST_SAVE
    } mfs_phase_t;

    // pins from the host
    typedef struct packed {
        logic proc_reset;
        logic clear_channel;
    } mfs_link_in_t;

    // pins toward the host
    typedef struct packed {
        logic proc_ready;
        logic user_error;
    } mfs_link_out_t;

    typedef struct packed {
        mfs_phase_t    phase;
        logic [4:0]    idx;
        logic [31:0]   boot_cnt;
        logic [3:0]    param_addr;
        logic [7:0]    errcode;
        logic [3:0]    irq_st;
        logic [3:0]    irq_mask;
        logic          dl_active;
        logic [31:0]   stage;
        logic [31:0]   prog;
        logic          aw_have;
        logic [7:0]    awaddr;
        logic          w_have;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          awready;
        logic          wready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
        mfs_link_out_t link_out;
        logic          irq;
    } mfs_state_t;

    localparam mfs_state_t STATE_RST = '{
        phase:    ST_RELOAD,
        errcode:  ERRCODE_RST,
        irq_mask: MASK_RST,
        prog:     PROG_RST,
        awready:  1'b1,
        wready:   1'b1,
        arready:  1'b1,
        default:  '0
    };

    // byte-lane merge of a write into an old value
    function automatic logic [31:0] mfs_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

endpackage

/* rtl/mfs_supervisor.sv */
`timescale 1ns/10ps
`default_nettype none

module mfs_supervisor
    import mfs_pkg::*;
#(
    parameter int unsigned RESTART_LEN = RESTART_CYCLES
) (
    // clock, reset, enable
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          ce,
    // host link pins
    input  wire mfs_link_in_t  link_in,
    output mfs_link_out_t      link_out,
    // axi4-lite write
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // interrupt
    output logic               irq
);
    localparam logic [31:0] BOOT_LAST = 32'(RESTART_LEN - 1);
    mfs_state_t  r, next_r;
    logic        work_we, nv_we, commit_now;
    logic [3:0]  work_waddr, work_raddr, nv_waddr, nv_raddr;
    logic [31:0] work_wdata, work_rdata, nv_wdata, nv_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // working parameters and their nonvolatile copy
    mfs_param_mem u_work (
        .aclk  (aclk),
        .ce    (ce),
        .we    (work_we),
        .waddr (work_waddr),
        .wdata (work_wdata),
        .raddr (work_raddr),
        .rdata (work_rdata)
    );

    mfs_param_mem u_nv (
        .aclk  (aclk),
        .ce    (ce),
        .we    (nv_we),
        .waddr (nv_waddr),
        .wdata (nv_wdata),
        .raddr (nv_raddr),
        .rdata (nv_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register read decode: bit 32 marks a mapped offset
    function automatic logic [32:0] reg_read(input logic [7:0] a);
        logic [32:0] v;
        v = {1'b1, 32'h0000_0000};
        case (a)
            OFS_CTRL:       v[31:0] = 32'h0000_0000;
            OFS_STATUS: begin
                v[STAT_READY] = r.link_out.proc_ready;
                v[STAT_BUSY]  = (r.phase != ST_READY);
                v[STAT_DL]    = r.dl_active;
                v[STAT_UERR]  = r.link_out.user_error;
                v[STAT_HELD]  = (r.phase == ST_HELD);
            end
            OFS_ERRCODE:    v[7:0]  = r.errcode;
            OFS_PARAM_ADDR: v[3:0]  = r.param_addr;
            OFS_PARAM_DATA: v[31:0] = work_rdata;
            OFS_PROG_STAGE: v[31:0] = r.stage;
            OFS_PROG:       v[31:0] = r.prog;
            OFS_IRQ_STATUS: v[3:0]  = r.irq_st;
            OFS_IRQ_MASK:   v[3:0]  = r.irq_mask;
            default:        v       = 33'h0_0000_0000;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic for bus slave, restart sequencer and download
    always_comb begin
        logic [32:0] old_v, rd_v;
        logic [31:0] wv, wm;
        logic [3:0]  ctrl, irq_clr, set_irq;
        logic        wr_go;
        old_v      = '0;
        rd_v       = '0;
        wv         = '0;
        wm         = '0;
        ctrl       = '0;
        irq_clr    = '0;
        set_irq    = '0;
        next_r     = r;
        commit_now = 1'b0;
        work_we    = 1'b0;
        work_waddr = r.param_addr;
        work_wdata = 32'h0000_0000;
        work_raddr = r.param_addr;
        nv_we      = 1'b0;
        nv_waddr   = r.idx[3:0];
        nv_wdata   = work_rdata;
        nv_raddr   = r.idx[3:0];

        // address and data channels are taken independently
        if (s_axi_awvalid && r.awready) begin
            next_r.aw_have = 1'b1;
            next_r.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready) begin
            next_r.w_have = 1'b1;
            next_r.wdata  = s_axi_wdata;
            next_r.wstrb  = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        // write once both halves are held
        wr_go = r.aw_have && r.w_have && !r.bvalid;
        if (wr_go) begin
            old_v          = reg_read(r.awaddr);
            wv             = mfs_merge(old_v[31:0], r.wdata, r.wstrb);
            wm             = mfs_merge(32'h0000_0000, r.wdata, r.wstrb);
            next_r.aw_have = 1'b0;
            next_r.w_have  = 1'b0;
            next_r.bvalid  = 1'b1;
            next_r.bresp   = old_v[32] ? RESP_OKAY : RESP_SLVERR;
            case (r.awaddr)
                OFS_CTRL:       ctrl = wm[3:0];
                OFS_ERRCODE:    next_r.errcode = wv[7:0];
                OFS_PARAM_ADDR: next_r.param_addr = wv[3:0];
                OFS_PARAM_DATA: begin
                    // working copy only; survives until the next restart
                    if (r.phase == ST_READY) begin
                        work_we    = 1'b1;
                        work_wdata = wv;
                    end
                end
                OFS_PROG_STAGE: begin
                    if (r.dl_active) begin
                        next_r.stage = wv;
                    end
                end
                OFS_IRQ_STATUS: irq_clr = wm[3:0];
                OFS_IRQ_MASK:   next_r.irq_mask = wv[3:0];
                default: ;
            endcase
        end

        // read answers in the cycle after the address is taken
        if (s_axi_arvalid && r.arready) begin
            rd_v          = reg_read(s_axi_araddr);
            next_r.rvalid = 1'b1;
            next_r.rdata  = rd_v[31:0];
            next_r.rresp  = rd_v[32] ? RESP_OKAY : RESP_SLVERR;
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end

        // restart sequencer
        case (r.phase)
            ST_HELD: begin
                if (!link_in.proc_reset) begin
                    next_r.phase = ST_RELOAD;
                    next_r.idx   = '0;
                end
            end
            ST_RELOAD: begin
                // copy store to working memory, one word behind the read
                if (r.idx != 5'h00) begin
                    work_we    = 1'b1;
                    work_waddr = 4'(r.idx - 5'h01);
                    work_wdata = nv_rdata;
                end
                if (r.idx == IDX_END) begin
                    next_r.phase    = ST_BOOT;
                    next_r.boot_cnt = '0;
                end else begin
                    next_r.idx = r.idx + 5'h01;
                end
            end
            ST_BOOT: begin
                if (r.boot_cnt == BOOT_LAST) begin
                    next_r.phase       = ST_READY;
                    set_irq[IRQ_READY] = 1'b1;
                end else begin
                    next_r.boot_cnt = r.boot_cnt + 32'h0000_0001;
                end
            end
            ST_READY: begin
                if (ctrl[CTRL_SAVE]) begin
                    next_r.phase = ST_SAVE;
                    next_r.idx   = '0;
                end
                if (ctrl[CTRL_DL_START]) begin
                    next_r.dl_active = 1'b1;
                end
            end
            ST_SAVE: begin
                work_raddr = r.idx[3:0];
                if (r.idx != 5'h00) begin
                    nv_we    = 1'b1;
                    nv_waddr = 4'(r.idx - 5'h01);
                end
                if (r.idx == IDX_END) begin
                    next_r.phase = ST_READY;
                end else begin
                    next_r.idx = r.idx + 5'h01;
                end
            end
            default: next_r.phase = ST_HELD;
        endcase

        // download ends in commit or abort; an abort keeps the old program
        if (r.dl_active && (ctrl[CTRL_DL_ABORT] || link_in.clear_channel
                            || link_in.proc_reset)) begin
            next_r.dl_active      = 1'b0;
            set_irq[IRQ_DL_ABORT] = 1'b1;
        end else if (r.dl_active && ctrl[CTRL_DL_COMMIT]) begin
            next_r.dl_active = 1'b0;
            next_r.prog      = r.stage;
            commit_now       = 1'b1;
        end

        // processor reset wins over the restart sequencer and memory writes; a save in flight is cut short
        if (link_in.proc_reset) begin
            if (r.phase != ST_HELD) begin
                set_irq[IRQ_RESET] = 1'b1;
            end
            next_r.phase    = ST_HELD;
            next_r.boot_cnt = '0;
            work_we         = 1'b0;
            nv_we           = 1'b0;
        end

        // user error flags, sticky bits cleared before set, so a set wins
        if (next_r.errcode != ERRCODE_RST && r.errcode == ERRCODE_RST) begin
            set_irq[IRQ_UERR] = 1'b1;
        end
        next_r.irq_st = (r.irq_st & ~irq_clr) | set_irq;
        next_r.irq    = |(next_r.irq_st & next_r.irq_mask);

        // bus readiness and pins, all registered
        next_r.awready             = !next_r.aw_have && !next_r.bvalid;
        next_r.wready              = !next_r.w_have && !next_r.bvalid;
        next_r.arready             = !next_r.rvalid;
        next_r.link_out.proc_ready = next_r.phase inside {ST_READY, ST_SAVE};
        next_r.link_out.user_error = (next_r.errcode != ERRCODE_RST);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; enable low freezes everything but the synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= STATE_RST;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign link_out      = r.link_out;
    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_arready = r.arready;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign s_axi_rvalid  = r.rvalid;
    assign irq           = r.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_reset_pulse;
        ce && link_in.proc_reset ##1 ce && !link_in.proc_reset;
    endsequence
    sequence s_boot_done;
        ce && r.phase == ST_BOOT && r.boot_cnt == BOOT_LAST && !link_in.proc_reset;
    endsequence
    a_reload_first: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reset_pulse |=> r.phase == ST_RELOAD && r.idx == 5'h00)
        else $error("reload did not start after reset release");
    a_ready_after_boot: assert property (@(posedge aclk) disable iff (!aresetn)
        s_boot_done |=> link_out.proc_ready && r.irq_st[IRQ_READY])
        else $error("ready not raised at end of restart time");
    a_ready_from_boot: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(link_out.proc_ready) |-> $past(r.phase) == ST_BOOT)
        else $error("ready raised without completing restart");
    a_ready_drop_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && link_in.proc_reset |=> !link_out.proc_ready && r.phase == ST_HELD)
        else $error("ready stayed high under processor reset");
    a_user_error_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && r.aw_have && r.w_have && !r.bvalid && r.awaddr == OFS_ERRCODE && r.wstrb[0]
        |=> link_out.user_error == ($past(r.wdata[7:0]) != ERRCODE_RST))
        else $error("user error pin disagrees with error code");
    a_uerr_irq_set: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(link_out.user_error) |-> r.irq_st[IRQ_UERR])
        else $error("user error did not set its status bit");
    a_prog_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        !(ce && commit_now) |=> $stable(r.prog))
        else $error("stored program changed without commit");
    a_abort_ends_dl: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && r.dl_active && link_in.proc_reset |=> !r.dl_active && r.irq_st[IRQ_DL_ABORT])
        else $error("download not aborted by processor reset");
endmodule // mfs_supervisor
`default_nettype wire

/* testbench/mfs_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module mfs_host_model
    import mfs_pkg::*;
#(
    // stands in for the 10 ms hold; the full count would make the run long
    parameter int unsigned HOLD_LEN = 4,
    // stands in for the 200 ms command timeout
    parameter int unsigned CMD_WAIT = 64
) (
    // clock
    input  wire logic          aclk,
    // link pins
    input  wire mfs_link_out_t link_out,
    output var  mfs_link_in_t  link_in
);

////////////////////////////////////////////////////////////////////////
    logic             scan_on  = 1'b0;
    logic             fatal    = 1'b0;
    logic             io_fault = 1'b0;
    mfs_link_out_t    stat_img = '0;
    logic [1:0][31:0] up_buf   = '0;

    initial link_in = '0;

    // cyclic status reader, the only setter of fatal; a pin with no level
    // means the module does not answer, and the image then goes stale
    always @(posedge aclk) begin
        if (link_in.proc_reset) begin
            fatal <= 1'b0;
        end else if (scan_on && !fatal) begin
            stat_img <= link_out;
            if ($isunknown(link_out)) begin
                fatal <= 1'b1;
            end
        end
    end

    // one-cycle pulse that puts the handshake back to its start state
    task automatic clear_pulse();
        @(posedge aclk);
        link_in.clear_channel <= 1'b1;
        @(posedge aclk);
        link_in.clear_channel <= 1'b0;
    endtask

    // full restart; n counts edges from release until ready is seen
    task automatic restart(output int n);
        @(posedge aclk);
        link_in.proc_reset <= 1'b1;
        repeat (HOLD_LEN) @(posedge aclk);
        link_in.proc_reset <= 1'b0;
        n = 0;
        // wait for ready before any command goes out
        do begin
            @(posedge aclk);
            #1 n++;
        end while (link_out.proc_ready !== 1'b1 && n < 1000);
        clear_pulse();
    endtask

    // module initializer; a module not ready within 1000 edges sets io_fault and leaves scanning off
    task automatic init();
        int k;
        k = 0;
        while (link_out.proc_ready !== 1'b1 && k < 1000) begin
            @(posedge aclk);
            k++;
        end
        io_fault = (k >= 1000);
        scan_on  = !io_fault;
    endtask

    // command executor: result preset first, nothing sent after a fatal,
    // a stalled exchange dropped after CMD_WAIT edges without raising fatal
    task automatic exec(output logic done);
        int k;
        done = 1'b0;
        k    = 0;
        if (fatal) return;
        while (link_out.proc_ready !== 1'b1 && k < CMD_WAIT) begin
            @(posedge aclk);
            k++;
        end
        done = (k < CMD_WAIT);
    endtask

    // upload buffer: slot 1 nonzero marks it valid, a fatal leaves slot 1 zero
    task automatic upload(input logic [31:0] w);
        up_buf[0] = w;
        up_buf[1] = fatal ? 32'h0000_0000 : 32'h0000_0001;
    endtask

endmodule // mfs_host_model

`default_nettype wire

/* testbench/mfs_supervisor_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module mfs_supervisor_tb
    import mfs_pkg::*;
;

    localparam int unsigned RLEN = 20;
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    logic          ce = 1'b1;
    mfs_link_in_t  link_in;
    mfs_link_out_t link_out;
    logic [7:0]    s_axi_awaddr = '0;
    logic [7:0]    s_axi_araddr = '0;
    logic [31:0]   s_axi_wdata = '0;
    logic [3:0]    s_axi_wstrb = 4'hF;
    logic          s_axi_awvalid = 1'b0;
    logic          s_axi_wvalid = 1'b0;
    logic          s_axi_bready = 1'b0;
    logic          s_axi_arvalid = 1'b0;
    logic          s_axi_rready = 1'b0;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    logic [31:0]   s_axi_rdata, d1, d2;
    logic [31:0]   rs = 32'h873E;
    logic [33:0]   expq[$];
    int            miscompares = 0;
    int            n_tests = 0;
    int            n;
    logic          ok_c;

    always #12.5 aclk = ~aclk;

    mfs_supervisor #(.RESTART_LEN(RLEN)) mfs_supervisor_inst (.aclk, .aresetn, .ce, .link_in,
        .link_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .irq);
    mfs_host_model mfs_host_model_inst (.aclk, .link_out, .link_in);

////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [33:0] ok(input logic [31:0] v);
        return {RESP_OKAY, v};
    endfunction

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({32'h0, s_axi_bresp}, {32'h0, r});
    endtask

    // expected answer is noted first; the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        expq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // read monitor
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
        end
    end

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #(25 * 4000);
        miscompares++;
        close_out();
    end

////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        mfs_host_model_inst.init();
        chk({33'h0, mfs_host_model_inst.io_fault}, 34'h0);
        rd(OFS_STATUS, ok(32'h1));
        rd(OFS_IRQ_MASK, ok(32'h0));
        rd(OFS_PROG, ok(PROG_RST));
        rd(OFS_ERRCODE, ok(32'h0));
        rd(8'h40, {RESP_SLVERR, 32'h0});
        wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
        // user error: pin, status, masked interrupt, one-to-clear
        wr(OFS_IRQ_STATUS, 32'hF);
        wr(OFS_IRQ_MASK, 32'h2);
        rs = lfsr(rs);
        wr(OFS_ERRCODE, {24'h0, rs[7:0] | 8'h01});
        repeat (2) @(posedge aclk);
        chk({32'h0, link_out.user_error, irq}, 34'h3);
        rd(OFS_STATUS, ok(32'h9));
        wr(OFS_IRQ_STATUS, 32'h2);
        wr(OFS_ERRCODE, 32'h0);
        repeat (2) @(posedge aclk);
        chk({32'h0, link_out.user_error, irq}, 34'h0);
        // saved parameter survives a restart, the unsaved one does not
        rs = lfsr(rs);
        d1 = rs;
        rs = lfsr(rs);
        d2 = rs;
        wr(OFS_PARAM_ADDR, 32'h3);
        wr(OFS_PARAM_DATA, d1);
        wr(OFS_CTRL, 32'h1 << CTRL_SAVE);
        repeat (20) @(posedge aclk);
        wr(OFS_PARAM_DATA, d2);
        wr(OFS_PARAM_ADDR, 32'h3);
        rd(OFS_PARAM_DATA, ok(d2));
        wr(OFS_IRQ_STATUS, 32'hF);
        mfs_host_model_inst.restart(n);
        chk(34'(n), 34'(17 + RLEN + 1));
        rd(OFS_IRQ_STATUS, ok(32'h9));
        wr(OFS_PARAM_ADDR, 32'h3);
        rd(OFS_PARAM_DATA, ok(d1));
        // commit, then aborts by clear channel and by control bit
        wr(OFS_CTRL, 32'h1 << CTRL_DL_START);
        wr(OFS_PROG_STAGE, d2);
        wr(OFS_CTRL, 32'h1 << CTRL_DL_COMMIT);
        rd(OFS_PROG, ok(d2));
        wr(OFS_CTRL, 32'h1 << CTRL_DL_START);
        wr(OFS_PROG_STAGE, d1);
        rd(OFS_STATUS, ok(32'h5));
        mfs_host_model_inst.clear_pulse();
        rd(OFS_PROG, ok(d2));
        rd(OFS_IRQ_STATUS, ok(32'hD));
        wr(OFS_CTRL, 32'h1 << CTRL_DL_START);
        wr(OFS_PROG_STAGE, d1);
        wr(OFS_CTRL, 32'h1 << CTRL_DL_ABORT);
        rd(OFS_PROG, ok(d2));
        rd(OFS_STATUS, ok(32'h1));
        // processor reset in mid-download aborts it and keeps the program
        wr(OFS_IRQ_STATUS, 32'hF);
        wr(OFS_CTRL, 32'h1 << CTRL_DL_START);
        wr(OFS_PROG_STAGE, d1);
        mfs_host_model_inst.restart(n);
        chk(34'(n), 34'(17 + RLEN + 1));
        rd(OFS_PROG, ok(d2));
        rd(OFS_IRQ_STATUS, ok(32'hD));
        // host side after a clean run: no fatal, valid upload, commands go out
        mfs_host_model_inst.upload(d2);
        chk({33'h0, mfs_host_model_inst.up_buf[1] != 32'h0}, 34'h1);
        mfs_host_model_inst.exec(ok_c);
        chk({33'h0, ok_c}, 34'h1);
        chk({33'h0, mfs_host_model_inst.fatal}, 34'h0);
        chk({32'h0, mfs_host_model_inst.stat_img}, {32'h0, link_out});
        close_out();
    end

endmodule // mfs_supervisor_tb

`default_nettype wire
